// file: fp_scan_pkg.sv
package fp_scan_pkg;
    // Scan geometry
    localparam int unsigned POS_W       = 5;
    localparam int unsigned NUM_POS     = 32;
    localparam logic [4:0]  LAST_POS    = 5'h1F;
    localparam int unsigned NUM_LED     = 3;
    // LED scan slots
    localparam logic [4:0]  LED_KNOB_POS = 5'h1D;
    localparam logic [4:0]  LED_AUTO_POS = 5'h1E;
    localparam logic [4:0]  LED_SAVE_POS = 5'h1F;
    // Timing at 10 MHz reference clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SETTLE_NS     = 300;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PHASE_W       = 3;
    // Debounce scans
    localparam int unsigned DEB_W         = 4;
    localparam logic [3:0]  DEB_DEFAULT   = 4'h3;
    // Reset values
    localparam logic [4:0]  POS_RESET     = 5'h00;
    localparam logic [2:0]  PHASE_RESET   = 3'h0;

    typedef enum logic [3:0]
    {
        ST_RESET   = 4'b0001,
        ST_ADVANCE = 4'b0010,
        ST_SETTLE  = 4'b0100,
        ST_SAMPLE  = 4'b1000
    } scan_state_t;
endpackage

// file: fp_scan_path.sv
module fp_scan_path
(
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    // Configuration
    input  wire logic [3:0]           i_deb_scans,
    // Indicator requests
    input  wire logic                 i_led_knob,
    input  wire logic                 i_led_auto,
    input  wire logic                 i_led_save,
    // Panel link
    output logic                      o_scan_rst,
    output logic                      o_scan_adv,
    input  wire logic                 i_sense,
    // Results
    output logic [31:0]               o_keys,
    output logic                      o_frame,
    output logic [2:0]                o_leds
);
    logic [1:0]               rst_sync;
    logic                     rst_n;
    fp_scan_pkg::scan_state_t state;
    logic [4:0]               pos;
    logic [2:0]               phase;
    logic [31:0]              raw;
    logic [3:0]               deb_cnt [32];

    // Per-slot actions happen only in the sample cycle
    function automatic logic sampling(input fp_scan_pkg::scan_state_t s);
        return s == fp_scan_pkg::ST_SAMPLE;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Scan sequencer: reset pulse, then advance / settle / sample per slot
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= fp_scan_pkg::ST_RESET;
            pos        <= fp_scan_pkg::POS_RESET;
            phase      <= fp_scan_pkg::PHASE_RESET;
            o_scan_rst <= 1'b1;
            o_scan_adv <= 1'b0;
            o_frame    <= 1'b0;
        end
        else
        begin
            o_frame <= 1'b0;
            unique case (state)
                fp_scan_pkg::ST_RESET:
                begin
                    o_scan_rst <= 1'b0;
                    pos        <= fp_scan_pkg::POS_RESET;
                    phase      <= fp_scan_pkg::PHASE_RESET;
                    state      <= fp_scan_pkg::ST_SETTLE;
                end
                fp_scan_pkg::ST_ADVANCE:
                begin
                    o_scan_adv <= 1'b0;
                    pos        <= pos + 5'h01;
                    phase      <= fp_scan_pkg::PHASE_RESET;
                    state      <= fp_scan_pkg::ST_SETTLE;
                end
                fp_scan_pkg::ST_SETTLE:
                begin
                    if (phase == 3'(fp_scan_pkg::SETTLE_CYC - 1))
                        state <= fp_scan_pkg::ST_SAMPLE;
                    else
                        phase <= phase + 3'h1;
                end
                fp_scan_pkg::ST_SAMPLE:
                begin
                    if (pos == fp_scan_pkg::LAST_POS)
                    begin
                        o_scan_rst <= 1'b1;
                        o_frame    <= 1'b1;
                        state      <= fp_scan_pkg::ST_RESET;
                    end
                    else
                    begin
                        o_scan_adv <= 1'b1;
                        state      <= fp_scan_pkg::ST_ADVANCE;
                    end
                end
            endcase
        end
    end

    // Raw per-slot sample of the sense line
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            raw <= 32'h0;
        else if (sampling(state))
            raw[pos] <= i_sense;
    end

    // Debounce: count stable scans per slot before accepting
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_keys <= 32'h0;
            for (int i = 0; i < 32; i++)
                deb_cnt[i] <= 4'h0;
        end
        else if (sampling(state))
        begin
            if (i_sense == o_keys[pos])
                deb_cnt[pos] <= 4'h0;
            else if (deb_cnt[pos] + 4'h1 >= i_deb_scans)
            begin
                o_keys[pos]  <= i_sense;
                deb_cnt[pos] <= 4'h0;
            end
            // First differing sample counts too, so N differing scans accept
            else if (deb_cnt[pos] == 4'h0 || i_sense == raw[pos])
                deb_cnt[pos] <= deb_cnt[pos] + 4'h1;
            else
                deb_cnt[pos] <= 4'h0;
        end
    end

    // LEDs latch their request when the counter reaches their slot
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_leds <= 3'h0;
        else if (sampling(state))
        begin
            if (pos == fp_scan_pkg::LED_KNOB_POS)
                o_leds[0] <= i_led_knob;
            if (pos == fp_scan_pkg::LED_AUTO_POS)
                o_leds[1] <= i_led_auto;
            if (pos == fp_scan_pkg::LED_SAVE_POS)
                o_leds[2] <= i_led_save;
        end
    end
endmodule

// Two-channel build: two independent paths side by side
module fp_scan_controller
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Configuration
    input  wire logic [3:0]  i_deb_scans,
    // Indicator requests, left half
    input  wire logic        i_led_knob,
    input  wire logic        i_led_auto,
    input  wire logic        i_led_save,
    // Left panel link
    output logic             o_l_scan_rst,
    output logic             o_l_scan_adv,
    input  wire logic        i_l_sense,
    // Right panel link
    output logic             o_r_scan_rst,
    output logic             o_r_scan_adv,
    input  wire logic        i_r_sense,
    // Results
    output logic [31:0]      o_l_keys,
    output logic [31:0]      o_r_keys,
    output logic             o_l_frame,
    output logic             o_r_frame,
    output logic [2:0]       o_leds
);
    fp_scan_path u_left
    (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_deb_scans(i_deb_scans),
        .i_led_knob (i_led_knob),
        .i_led_auto (i_led_auto),
        .i_led_save (i_led_save),
        .o_scan_rst (o_l_scan_rst),
        .o_scan_adv (o_l_scan_adv),
        .i_sense    (i_l_sense),
        .o_keys     (o_l_keys),
        .o_frame    (o_l_frame),
        .o_leds     (o_leds)
    );

    fp_scan_path u_right
    (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_deb_scans(i_deb_scans),
        .i_led_knob (1'b0),
        .i_led_auto (1'b0),
        .i_led_save (1'b0),
        .o_scan_rst (o_r_scan_rst),
        .o_scan_adv (o_r_scan_adv),
        .i_sense    (i_r_sense),
        .o_keys     (o_r_keys),
        .o_frame    (o_r_frame),
        .o_leds     ()
    );
endmodule

// file: fp_scan_asserts.sv
module fp_scan_asserts
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        o_l_scan_rst,
    input wire logic        o_l_scan_adv,
    input wire logic        o_r_scan_adv,
    input wire logic        o_r_scan_rst,
    input wire logic        o_l_frame,
    input wire logic        o_r_frame,
    input wire logic [31:0] o_l_keys,
    input wire logic [2:0]  o_leds
);
    logic [5:0] n_adv;

    // Advance pulses since the last scan reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            n_adv <= 6'h00;
        else
            n_adv <= o_l_scan_rst ? 6'h00 : n_adv + 6'(o_l_scan_adv);
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Pulse cycle is followed by three settle cycles and the sample cycle
    sequence slot_gap_s;
        !o_l_scan_adv[*4];
    endsequence

    chk_adv_spacing: assert property (o_l_scan_adv |=> slot_gap_s ##1 (o_l_scan_adv || o_l_scan_rst))
        else $error("adv spacing");
    chk_rst_settle: assert property ($fell(o_l_scan_rst) |-> slot_gap_s ##1 o_l_scan_adv)
        else $error("first advance after reset");
    chk_frame_pulse: assert property (o_l_frame |-> o_l_scan_rst ##1 !o_l_scan_rst)
        else $error("frame without reset pulse");
    chk_frame_count: assert property (o_l_frame |-> n_adv == 6'h1F)
        else $error("positions per frame");
    chk_line_overlap: assert property (!(o_l_scan_adv && o_l_scan_rst))
        else $error("reset and advance together");
    chk_right_lockstep: assert property (o_r_scan_adv == o_l_scan_adv)
        else $error("paths out of step");
    chk_right_reset: assert property (o_r_scan_rst == o_l_scan_rst)
        else $error("right scan reset out of step");
    chk_right_frame: assert property (o_r_frame |-> o_r_scan_rst ##1 !o_r_scan_rst)
        else $error("right frame without reset pulse");
    chk_key_step: assert property ($changed(o_l_keys) |-> $onehot(o_l_keys ^ $past(o_l_keys)))
        else $error("several keys in one step");
    chk_led_slot: assert property ($changed(o_leds) |-> (n_adv >= 6'h1D || $past(o_l_scan_rst)))
        else $error("led outside its slot");
endmodule

bind fp_scan_controller fp_scan_asserts chk
(
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .o_l_scan_rst (o_l_scan_rst),
    .o_l_scan_adv (o_l_scan_adv),
    .o_r_scan_adv (o_r_scan_adv),
    .o_r_scan_rst (o_r_scan_rst),
    .o_l_frame    (o_l_frame),
    .o_r_frame    (o_r_frame),
    .o_l_keys     (o_l_keys),
    .o_leds       (o_leds)
);

// file: fp_panel_model.sv
module fp_panel_model
(
    input  wire logic        i_clk,
    input  wire logic        i_scan_rst,
    input  wire logic        i_scan_adv,
    input  wire logic [31:0] i_sw,
    output logic             o_sense
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] pos;

    always_ff @(posedge i_clk)
    begin
        if (i_scan_rst)
            pos <= 5'h00;
        else if (i_scan_adv)
            pos <= pos + 5'h01;
    end

    // Buffered switch states, encoders already filtered
    assign o_sense = i_sw[pos];
endmodule

// file: fp_scan_controller_bench.sv
module fp_scan_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        l_rst, l_adv, r_rst, r_adv, l_sense, r_sense, l_frame;
    logic [3:0]  deb = 4'h0;
    logic [2:0]  led_req = 3'h0, leds;
    logic [31:0] l_sw = 32'h0, r_sw = 32'h0, l_keys, r_keys;
    logic [66:0] q[$];
    logic [66:0] cur = '0, exp_v;
    logic [3:0]  debs[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'hF};
    int          n_fail = 0, tests_run = 0, seed = 2;

    always #50 clk = ~clk;

    fp_scan_controller DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_deb_scans(deb), .i_led_knob(led_req[0]),
        .i_led_auto(led_req[1]), .i_led_save(led_req[2]), .o_l_scan_rst(l_rst), .o_l_scan_adv(l_adv),
        .i_l_sense(l_sense), .o_r_scan_rst(r_rst), .o_r_scan_adv(r_adv), .i_r_sense(r_sense),
        .o_l_keys(l_keys), .o_r_keys(r_keys), .o_l_frame(l_frame), .o_r_frame(), .o_leds(leds));
    fp_panel_model left (.i_clk(clk), .i_scan_rst(l_rst), .i_scan_adv(l_adv), .i_sw(l_sw), .o_sense(l_sense));
    fp_panel_model right (.i_clk(clk), .i_scan_rst(r_rst), .i_scan_adv(r_adv), .i_sw(r_sw), .o_sense(r_sense));

    task automatic check(input string what, input logic [66:0] seen, input logic [66:0] want);
        tests_run++;
        if (seen !== want)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_frame;
        @(negedge clk iff l_frame === 1'b1);
        @(negedge clk);
    endtask

    // New pattern; a short debounce accepts it within one frame, a long one holds the old keys
    task automatic round(input logic [3:0] d);
        logic [66:0] nxt;
        nxt = {3'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        deb = d;
        {led_req, r_sw, l_sw} = nxt;
        q.push_back({nxt[66:64], (d <= 4'h1) ? nxt[63:0] : cur[63:0]});
        repeat ((d <= 4'h1) ? 1 : d - 1) wait_frame();
        q.push_back(nxt);
        wait_frame();
        cur = nxt;
        $display("Round with debounce %0d done", d);
    endtask

    // Compare the cycle after the frame pulse, once the last slot has landed
    initial forever
    begin
        @(negedge clk iff (l_frame === 1'b1 && q.size() > 0));
        exp_v = q.pop_front();
        @(negedge clk);
        check("leds and keys", {leds, r_keys, l_keys}, exp_v);
    end

    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        wait_frame();
        foreach (debs[i]) round(debs[i]);
        repeat (77) @(negedge clk);
        rst_n = 1'b0;
        {led_req, r_sw, l_sw} = '0;
        cur = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        wait_frame();
        round(4'h3);
        complete_run();
    end

    // About five times the expected run
    initial
    begin
        #3000000;
        n_fail++;
        complete_run();
    end
endmodule
